// >>> src/trellis_ctrl_map.svh
// register offsets, field positions, reset values and owed-cycle limit of the encoder control bank
`ifndef TRELLIS_CTRL_MAP_SVH
`define TRELLIS_CTRL_MAP_SVH

`define OFS_ENC_CTRL_ONE      8'h06
`define OFS_ENC_CTRL_TWO      8'h07
`define OFS_SYNC_LENGTH       8'h08
`define OFS_SYNC_THRESHOLD    8'h09
`define OFS_DEC_IN_STROBE     8'h0E
`define OFS_DEC_OUT_STROBE    8'h0F
`define OFS_ENC_IN_STROBE     8'h11
`define OFS_ENC_OUT_STROBE    8'h12
`define OFS_SYNC_APPLY        8'h17
`define OFS_STATUS            8'h18

`define BIT_SOFT_RESET        1
`define BIT_PERIPH_MODE       3
`define BIT_DIFF_ENABLE       4
`define BIT_RATE_16PSK        7

`define RST_ENC_CTRL          8'h00
`define RST_SYNC_COUNT        8'h00
`define RST_RDATA             8'h00

`define OWE_MAX               2'h3

`endif

// >>> src/trellis_ctrl_pkg.sv
// state types of the encoder control bank
package trellis_ctrl_pkg;

    typedef struct packed {
        logic [7:0] ctrl_one;
        logic [7:0] ctrl_two;
        logic       soft_rst;
        logic [7:0] rdata;
    } regs_state_t;

    typedef struct packed {
        logic [3:0]      clk;
        logic [3:0][1:0] owe;
    } strobe_state_t;

    typedef struct packed {
        logic [7:0] len_stage;
        logic [7:0] thr_stage;
        logic [7:0] len_act;
        logic [7:0] thr_act;
        logic       restart;
        logic       armed;
    } sync_state_t;

endpackage : trellis_ctrl_pkg

// >>> src/reg_wr_if.sv
// write path from the register port to a sub-unit, with the unit's state coming back
`timescale 1ns/1ns
interface reg_wr_if;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] state;

    modport host (output wr, addr, wdata, input state);
    modport unit (input wr, addr, wdata, output state);
endinterface : reg_wr_if

// >>> src/coder_clock_strobes.sv
// software clock strobes: each write to a strobe register owes one clock cycle
`timescale 1ns/1ns
`include "trellis_ctrl_map.svh"
module coder_clock_strobes
    import trellis_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // register writes
    reg_wr_if.unit          bus,
    // clocks: 0 dec in, 1 dec out, 2 enc in, 3 enc out
    output logic      [3:0] clk_o
);

    localparam logic [7:0] STROBE_OFS [4] = '{`OFS_DEC_IN_STROBE, `OFS_DEC_OUT_STROBE,
                                              `OFS_ENC_IN_STROBE, `OFS_ENC_OUT_STROBE};

    strobe_state_t   state_q;
    strobe_state_t   state_d;
    logic [3:0]      clk_n;
    logic [3:0][1:0] owe_n;

    // a clock cycle needs a low phase too, so writes closer than two cycles are queued;
    // more than three owed cycles saturate
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_ch
            logic       hit;
            logic       fire;
            logic [2:0] sum;
            assign hit      = bus.wr && (bus.addr == STROBE_OFS[i]);
            assign fire     = !state_q.clk[i] && (hit || (state_q.owe[i] != 2'h0));
            assign sum      = {1'b0, state_q.owe[i]} + {2'h0, hit} - {2'h0, fire};
            assign clk_n[i] = fire; // [RULE_08] [RULE_09] [RULE_10] [RULE_11]
            assign owe_n[i] = (sum > {1'b0, `OWE_MAX}) ? `OWE_MAX : sum[1:0];
        end
    endgenerate

    always_comb begin
        state_d     = state_q;
        state_d.clk = clk_n;
        state_d.owe = owe_n;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign clk_o     = state_q.clk;
    assign bus.state = {4'h0, state_q.clk | {|state_q.owe[3], |state_q.owe[2],
                                             |state_q.owe[1], |state_q.owe[0]}};

endmodule : coder_clock_strobes

// >>> src/sync_test_params.sv
// staged length and threshold of the synchronization monitor, applied together on demand
`timescale 1ns/1ns
`include "trellis_ctrl_map.svh"
module sync_test_params
    import trellis_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // register writes
    reg_wr_if.unit          bus,
    // applied values
    output logic      [7:0] length_o,
    output logic      [7:0] threshold_o,
    output logic            restart_o
);

    sync_state_t state_q;
    sync_state_t state_d;

    always_comb begin
        state_d         = state_q;
        state_d.restart = 1'b0;
        if (bus.wr) begin
            case (bus.addr)
                `OFS_SYNC_LENGTH:    state_d.len_stage = bus.wdata; // [RULE_06]
                `OFS_SYNC_THRESHOLD: state_d.thr_stage = bus.wdata; // [RULE_07]
                `OFS_SYNC_APPLY: begin
                    // staging keeps a running test steady while new counts are loaded
                    state_d.len_act = state_q.len_stage;
                    state_d.thr_act = state_q.thr_stage;
                    state_d.restart = 1'b1; // [RULE_13]
                    state_d.armed   = 1'b1;
                end
                default: state_d.armed = state_q.armed;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_q <= {`RST_SYNC_COUNT, `RST_SYNC_COUNT, `RST_SYNC_COUNT, `RST_SYNC_COUNT,
                        1'b0, 1'b0};
        end else begin
            state_q <= state_d;
        end
    end

    assign length_o    = state_q.len_act;
    assign threshold_o = state_q.thr_act;
    assign restart_o   = state_q.restart;
    assign bus.state   = {7'h00, state_q.armed};

endmodule : sync_test_params

// >>> src/trellis_encoder_ctrl_regs.sv
// register bank for the trellis encoder control, sync monitor counts and clock strobes
`timescale 1ns/1ns
`include "trellis_ctrl_map.svh"
////////////////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE_01: ctrl one bit 1 rising resets coder
// RULE_02: host uses either soft or pin reset
// RULE_03: ctrl two bit 3 selects peripheral data
// RULE_04: ctrl two bit 4 enables differential encoder
// RULE_05: ctrl two bit 7 selects 16-PSK rate
// RULE_06: length register sets sync test length
// RULE_07: threshold register sets normalization threshold
// RULE_08: any write pulses decoder input clock once
// RULE_09: any write pulses decoder output clock once
// RULE_10: any write pulses encoder input clock once
// RULE_11: any write pulses encoder output clock once
// RULE_12: host holds matching clock pin low
// RULE_13: apply write loads counts, restarts test
// RULE_14: host writes fixed bits to constants
////////////////////////////////////////////////////////////////////////////////////////////
module trellis_encoder_ctrl_regs
    import trellis_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic       CLK_SYS_I,
    input  wire logic       NRST_I,
    // register port
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    // encoder control
    output logic            ENC_SOFT_RESET_O,
    output logic            ENC_PERIPH_MODE_O,
    output logic            DIFF_ENCODER_ENABLE_O,
    output logic            ENC_RATE_16PSK_O,
    // synchronization monitor
    output logic      [7:0] SYNC_LENGTH_O,
    output logic      [7:0] SYNC_THRESHOLD_O,
    output logic            SYNC_TEST_RESTART_O,
    // software coder clocks
    output logic            DECODER_SYMBOL_IN_CLOCK_O,
    output logic            DECODER_DATA_OUT_CLOCK_O,
    output logic            ENCODER_DATA_IN_CLOCK_O,
    output logic            ENCODER_SYMBOL_OUT_CLOCK_O
);

    ////////////////////////////////////////////////////////////////////////////////////////
    // state and sub-unit links

    regs_state_t state_q;
    regs_state_t state_d;
    logic [3:0]  strobe_clk;

    reg_wr_if strobe_bus ();
    reg_wr_if sync_bus ();

    assign strobe_bus.wr    = WR_I;
    assign strobe_bus.addr  = ADDR_I;
    assign strobe_bus.wdata = WDATA_I;
    assign sync_bus.wr      = WR_I;
    assign sync_bus.addr    = ADDR_I;
    assign sync_bus.wdata   = WDATA_I;

    ////////////////////////////////////////////////////////////////////////////////////////
    // control registers and read path

    always_comb begin
        state_d          = state_q;
        state_d.soft_rst = 1'b0;
        state_d.rdata    = `RST_RDATA;
        if (WR_I && (ADDR_I == `OFS_ENC_CTRL_ONE)) begin
            state_d.ctrl_one = WDATA_I;
            // only the 0-to-1 edge acts; holding the bit at 1 does nothing further
            state_d.soft_rst = WDATA_I[`BIT_SOFT_RESET]
                               & ~state_q.ctrl_one[`BIT_SOFT_RESET]; // [RULE_01]
        end
        if (WR_I && (ADDR_I == `OFS_ENC_CTRL_TWO)) begin
            state_d.ctrl_two = WDATA_I; // [RULE_03] [RULE_04] [RULE_05]
        end
        if (RD_I) begin
            // control registers read back so software can check the fixed bits it wrote
            case (ADDR_I)
                `OFS_ENC_CTRL_ONE: state_d.rdata = state_q.ctrl_one;
                `OFS_ENC_CTRL_TWO: state_d.rdata = state_q.ctrl_two;
                `OFS_SYNC_LENGTH: state_d.rdata = SYNC_LENGTH_O;
                `OFS_SYNC_THRESHOLD: state_d.rdata = SYNC_THRESHOLD_O;
                `OFS_STATUS: state_d.rdata = {2'h0, state_q.soft_rst, sync_bus.state[0],
                                              strobe_bus.state[3:0]};
                default: state_d.rdata = `RST_RDATA;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            state_q <= {`RST_ENC_CTRL, `RST_ENC_CTRL, 1'b0, `RST_RDATA};
        end else begin
            state_q <= state_d;
        end
    end

    assign RDATA_O               = state_q.rdata;
    assign ENC_SOFT_RESET_O      = state_q.soft_rst;
    assign ENC_PERIPH_MODE_O     = state_q.ctrl_two[`BIT_PERIPH_MODE];
    // only the encoder side; decoder differential logic has its own enable elsewhere
    assign DIFF_ENCODER_ENABLE_O = state_q.ctrl_two[`BIT_DIFF_ENABLE];
    assign ENC_RATE_16PSK_O      = state_q.ctrl_two[`BIT_RATE_16PSK];

    ////////////////////////////////////////////////////////////////////////////////////////
    // sub-units

    coder_clock_strobes u_strobes (
        .clk_i  (CLK_SYS_I),
        .nrst_i (NRST_I),
        .bus    (strobe_bus.unit),
        .clk_o  (strobe_clk)
    );

    sync_test_params u_sync (
        .clk_i       (CLK_SYS_I),
        .nrst_i      (NRST_I),
        .bus         (sync_bus.unit),
        .length_o    (SYNC_LENGTH_O),
        .threshold_o (SYNC_THRESHOLD_O),
        .restart_o   (SYNC_TEST_RESTART_O)
    );

    assign DECODER_SYMBOL_IN_CLOCK_O  = strobe_clk[0]; // [RULE_08]
    assign DECODER_DATA_OUT_CLOCK_O   = strobe_clk[1]; // [RULE_09]
    assign ENCODER_DATA_IN_CLOCK_O    = strobe_clk[2]; // [RULE_10]
    assign ENCODER_SYMBOL_OUT_CLOCK_O = strobe_clk[3]; // [RULE_11]

    ////////////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!NRST_I);

    a_soft_reset_edge: assert property ( // [RULE_01]
        (WR_I && (ADDR_I == `OFS_ENC_CTRL_ONE) && WDATA_I[`BIT_SOFT_RESET]
         && !state_q.ctrl_one[`BIT_SOFT_RESET])
        |=> ENC_SOFT_RESET_O ##1 !ENC_SOFT_RESET_O || $past(WR_I)
    ) else $error("soft reset did not pulse on rising bit");

    a_soft_reset_cause: assert property ( // [RULE_01]
        ENC_SOFT_RESET_O |-> $past(WR_I) && ($past(ADDR_I) == `OFS_ENC_CTRL_ONE)
                             && $past(WDATA_I[`BIT_SOFT_RESET])
    ) else $error("soft reset pulsed without a rising write");

    a_periph_mode_set: assert property ( // [RULE_03]
        (WR_I && (ADDR_I == `OFS_ENC_CTRL_TWO))
        |=> ENC_PERIPH_MODE_O == $past(WDATA_I[`BIT_PERIPH_MODE])
    ) else $error("peripheral mode does not follow write");

    a_diff_enable_set: assert property ( // [RULE_04]
        (WR_I && (ADDR_I == `OFS_ENC_CTRL_TWO))
        |=> DIFF_ENCODER_ENABLE_O == $past(WDATA_I[`BIT_DIFF_ENABLE])
    ) else $error("differential enable does not follow write");

    a_diff_enable_hold: assert property ( // [RULE_04]
        !(WR_I && (ADDR_I == `OFS_ENC_CTRL_TWO))
        |=> $stable(DIFF_ENCODER_ENABLE_O) && $stable(ENC_PERIPH_MODE_O)
    ) else $error("encoder mode bits changed without a write");

    a_rate_select_set: assert property ( // [RULE_05]
        (WR_I && (ADDR_I == `OFS_ENC_CTRL_TWO))
        |=> ENC_RATE_16PSK_O == $past(WDATA_I[`BIT_RATE_16PSK])
    ) else $error("rate select does not follow write");

    a_length_apply: assert property ( // [RULE_06]
        (WR_I && (ADDR_I == `OFS_SYNC_LENGTH)) ##1 (WR_I && (ADDR_I == `OFS_SYNC_APPLY))
        |=> SYNC_LENGTH_O == $past(WDATA_I, 2)
    ) else $error("length count not applied");

    a_threshold_apply: assert property ( // [RULE_07]
        (WR_I && (ADDR_I == `OFS_SYNC_THRESHOLD)) ##1 (WR_I && (ADDR_I == `OFS_SYNC_APPLY))
        |=> SYNC_THRESHOLD_O == $past(WDATA_I, 2)
    ) else $error("threshold count not applied");

    a_counts_hold: assert property ( // [RULE_13]
        !(WR_I && (ADDR_I == `OFS_SYNC_APPLY))
        |=> $stable(SYNC_LENGTH_O) && $stable(SYNC_THRESHOLD_O) && !SYNC_TEST_RESTART_O
    ) else $error("sync counts moved or restart without apply write");

    a_restart_pulse: assert property ( // [RULE_13]
        (WR_I && (ADDR_I == `OFS_SYNC_APPLY)) |=> SYNC_TEST_RESTART_O
    ) else $error("apply write did not restart the test");

    a_dec_in_clock: assert property ( // [RULE_08]
        (WR_I && (ADDR_I == `OFS_DEC_IN_STROBE)) |-> ##[1:2] DECODER_SYMBOL_IN_CLOCK_O
    ) else $error("decoder input clock missing after strobe");

    a_dec_out_clock: assert property ( // [RULE_09]
        (WR_I && (ADDR_I == `OFS_DEC_OUT_STROBE)) |-> ##[1:2] DECODER_DATA_OUT_CLOCK_O
    ) else $error("decoder output clock missing after strobe");

    a_enc_in_clock: assert property ( // [RULE_10]
        (WR_I && (ADDR_I == `OFS_ENC_IN_STROBE)) |-> ##[1:2] ENCODER_DATA_IN_CLOCK_O
    ) else $error("encoder input clock missing after strobe");

    a_enc_out_clock: assert property ( // [RULE_11]
        (WR_I && (ADDR_I == `OFS_ENC_OUT_STROBE)) |-> ##[1:2] ENCODER_SYMBOL_OUT_CLOCK_O
    ) else $error("encoder output clock missing after strobe");

    a_clock_one_cycle: assert property ( // [RULE_08] [RULE_09] [RULE_10] [RULE_11]
        |strobe_clk |=> (strobe_clk & $past(strobe_clk)) == 4'h0
    ) else $error("software clock high for more than one cycle");

    a_clock_idle: assert property ( // [RULE_08] [RULE_09] [RULE_10] [RULE_11]
        (!WR_I && (strobe_bus.state[3:0] == 4'h0)) |=> strobe_clk == 4'h0
    ) else $error("software clock without a strobe write");

    // read data stand only in the cycle after the strobe, so an or-tied bus sees zero
    a_rdata_idle: assert property (
        !RD_I |=> RDATA_O == 8'h00
    ) else $error("read data not zero outside a read");

    a_soft_reset_once: assert property ( // [RULE_01]
        ENC_SOFT_RESET_O |=> !ENC_SOFT_RESET_O
    ) else $error("soft reset longer than one cycle");

    a_soft_reset_level: assert property ( // [RULE_01]
        (WR_I && (ADDR_I == `OFS_ENC_CTRL_ONE) && state_q.ctrl_one[`BIT_SOFT_RESET])
        |=> !ENC_SOFT_RESET_O
    ) else $error("soft reset pulsed while bit already set");

    a_length_read: assert property ( // [RULE_06]
        (RD_I && (ADDR_I == `OFS_SYNC_LENGTH)) |=> RDATA_O == $past(SYNC_LENGTH_O)
    ) else $error("length count readback wrong");

    a_threshold_read: assert property ( // [RULE_07]
        (RD_I && (ADDR_I == `OFS_SYNC_THRESHOLD)) |=> RDATA_O == $past(SYNC_THRESHOLD_O)
    ) else $error("threshold count readback wrong");

    a_status_applied: assert property ( // [RULE_13]
        (WR_I && (ADDR_I == `OFS_SYNC_APPLY)) |=> sync_bus.state[0]
    ) else $error("apply write not reported in status");

    a_strobe_busy: assert property ( // [RULE_08]
        (WR_I && (ADDR_I == `OFS_DEC_IN_STROBE)) |=> strobe_bus.state[0]
    ) else $error("decoder input clock not busy after strobe");

    c_soft_reset: cover property (ENC_SOFT_RESET_O);
    c_test_restart: cover property (
        (WR_I && (ADDR_I == `OFS_SYNC_LENGTH)) ##[1:4] SYNC_TEST_RESTART_O
    );
    c_queued_clock: cover property (
        DECODER_SYMBOL_IN_CLOCK_O ##1 !DECODER_SYMBOL_IN_CLOCK_O ##1 DECODER_SYMBOL_IN_CLOCK_O
    );
    c_status_read: cover property ((RD_I && (ADDR_I == `OFS_STATUS)) ##1 (RDATA_O != 8'h00));

endmodule : trellis_encoder_ctrl_regs

// >>> tb/host_bus_model.sv
// host processor model that drives the register port of the encoder control bank
`timescale 1ns/1ns
module host_bus_model (
    // clock
    input  wire logic       clk_i,
    // register port
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o,
    input  wire logic [7:0] rdata_i,
    // pins that compete with software control
    output logic            enc_reset_pin_o,
    output logic      [3:0] ext_clk_pin_o
);
    // software reset and software clocks are used, so the pins stay low
    assign enc_reset_pin_o = 1'b0;
    assign ext_clk_pin_o   = 4'h0;

    initial begin
        addr_o  = 8'h00;
        wdata_o = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        // stale data is not left on the bus
        wdata_o <= ~d;
    endtask : write_reg

    // back-to-back writes with no idle cycle between them
    task automatic write_pair(input logic [7:0] a0, input logic [7:0] d0,
                              input logic [7:0] a1, input logic [7:0] d1);
        @(posedge clk_i);
        addr_o  <= a0;
        wdata_o <= d0;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        addr_o  <= a1;
        wdata_o <= d1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        wdata_o <= ~d1;
    endtask : write_pair

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        @(negedge clk_i);
        d = rdata_i;
    endtask : read_reg

    // fixed bits forced to their constants whatever the caller asks
    task automatic write_ctrl_one(input logic [7:0] d);
        write_reg(8'h06, (d & 8'h02) | 8'h84);
    endtask : write_ctrl_one

    task automatic write_ctrl_two(input logic [7:0] d);
        write_reg(8'h07, d & 8'h98);
    endtask : write_ctrl_two
endmodule : host_bus_model

// >>> tb/trellis_encoder_ctrl_regs_tb.sv
// self-checking testbench of the encoder control register bank
`timescale 1ns/1ns
module trellis_encoder_ctrl_regs_tb;
    logic       clk_sys;
    logic       nrst;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       soft_rst;
    logic       periph;
    logic       diff_en;
    logic       rate16;
    logic [7:0] sync_len;
    logic [7:0] sync_thr;
    logic       restart;
    logic [3:0] pulse_vec;
    int         pulse_cnt [6];
    int         n_fail;
    int         check_count;

    initial clk_sys = 1'b0;
    always #25 clk_sys = ~clk_sys;

    host_bus_model u_host (
        .clk_i           (clk_sys),
        .addr_o          (addr),
        .wdata_o         (wdata),
        .wr_o            (wr),
        .rd_o            (rd),
        .rdata_i         (rdata),
        .enc_reset_pin_o (),
        .ext_clk_pin_o   ()
    );

    trellis_encoder_ctrl_regs u_dut (
        .CLK_SYS_I                  (clk_sys),
        .NRST_I                     (nrst),
        .ADDR_I                     (addr),
        .WDATA_I                    (wdata),
        .WR_I                       (wr),
        .RD_I                       (rd),
        .RDATA_O                    (rdata),
        .ENC_SOFT_RESET_O           (soft_rst),
        .ENC_PERIPH_MODE_O          (periph),
        .DIFF_ENCODER_ENABLE_O      (diff_en),
        .ENC_RATE_16PSK_O           (rate16),
        .SYNC_LENGTH_O              (sync_len),
        .SYNC_THRESHOLD_O           (sync_thr),
        .SYNC_TEST_RESTART_O        (restart),
        .DECODER_SYMBOL_IN_CLOCK_O  (pulse_vec[0]),
        .DECODER_DATA_OUT_CLOCK_O   (pulse_vec[1]),
        .ENCODER_DATA_IN_CLOCK_O    (pulse_vec[2]),
        .ENCODER_SYMBOL_OUT_CLOCK_O (pulse_vec[3])
    );

    // slots 4 and 5 count soft reset and restart pulses
    always @(posedge clk_sys) begin
        for (int i = 0; i < 4; i++) begin
            if (pulse_vec[i] === 1'b1) pulse_cnt[i]++;
        end
        if (soft_rst === 1'b1) pulse_cnt[4]++;
        if (restart === 1'b1) pulse_cnt[5]++;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic t_reset;
        logic [7:0] d;
        #1;
        chk("outputs after reset", 8'h00, {3'h0, soft_rst, periph, diff_en, rate16, restart});
        chk("clocks after reset", 8'h00, {4'h0, pulse_vec[3:0]});
        u_host.read_reg(8'h0D, d);
        chk("unmapped read", 8'h00, d);
        $display("test reset done");
    endtask : t_reset

    task automatic t_control;
        logic [7:0] tbl [5] = '{8'h08, 8'h10, 8'h80, 8'h98, 8'h00};
        logic [7:0] d;
        foreach (tbl[i]) begin
            u_host.write_ctrl_two(tbl[i]);
            #1;
            chk("mode bits", {5'h00, tbl[i][7], tbl[i][4], tbl[i][3]},
                {5'h00, rate16, diff_en, periph});
            u_host.read_reg(8'h07, d);
            chk("ctrl two readback", tbl[i], d);
        end
        $display("test control done");
    endtask : t_control

    task automatic t_soft_reset;
        int base [6];
        base = pulse_cnt;
        u_host.write_ctrl_one(8'h00);
        u_host.write_ctrl_one(8'h02);
        #1;
        chk("soft reset on rise", 8'h01, {7'h00, soft_rst});
        u_host.write_ctrl_one(8'h02);
        u_host.write_ctrl_one(8'h00);
        u_host.write_ctrl_one(8'h02);
        repeat (3) @(posedge clk_sys);
        chk("soft reset pulses", 8'h02, 8'(pulse_cnt[4] - base[4]));
        $display("test soft reset done");
    endtask : t_soft_reset

    task automatic t_sync;
        logic [7:0] d;
        u_host.write_reg(8'h08, 8'hA5);
        u_host.write_reg(8'h09, 8'h3C);
        #1;
        chk("length before apply", 8'h00, sync_len);
        u_host.write_reg(8'h17, 8'h00);
        #1;
        chk("length", 8'hA5, sync_len);
        chk("threshold", 8'h3C, sync_thr);
        chk("restart", 8'h01, {7'h00, restart});
        @(posedge clk_sys);
        #1;
        chk("restart end", 8'h00, {7'h00, restart});
        u_host.read_reg(8'h08, d);
        chk("length readback", 8'hA5, d);
        u_host.read_reg(8'h09, d);
        chk("threshold readback", 8'h3C, d);
        u_host.read_reg(8'h18, d);
        chk("status after apply", 8'h10, d);
        u_host.write_pair(8'h08, 8'h5E, 8'h17, 8'h00);
        #1;
        chk("length back to back", 8'h5E, sync_len);
        chk("threshold kept", 8'h3C, sync_thr);
        u_host.write_pair(8'h09, 8'h77, 8'h17, 8'h00);
        #1;
        chk("threshold back to back", 8'h77, sync_thr);
        chk("length kept", 8'h5E, sync_len);
        $display("test sync done");
    endtask : t_sync

    task automatic t_strobes;
        logic [7:0] ofs [4] = '{8'h0E, 8'h0F, 8'h11, 8'h12};
        int base [6];
        foreach (ofs[i]) begin
            base = pulse_cnt;
            u_host.write_reg(ofs[i], 8'h5A);
            #1;
            chk("clock vector", 8'(1 << i),
                {4'h0, pulse_vec});
            u_host.write_reg(ofs[i], 8'hFF);
            // two writes in a row: the second is owed and fires after a low cycle
            u_host.write_pair(ofs[i], 8'h00, ofs[i], 8'hFF);
            u_host.write_reg(8'h0D, 8'h00);
            repeat (4) @(posedge clk_sys);
            for (int j = 0; j < 4; j++) begin
                chk("clock pulses", (j == i) ? 8'h04 : 8'h00,
                    8'(pulse_cnt[j] - base[j]));
            end
        end
        $display("test strobes done");
    endtask : t_strobes

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        nrst = 1'b0;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_control();
        t_soft_reset();
        t_sync();
        t_strobes();
        report_and_stop();
    end

    // the tests need well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_fail++;
        $display("unexpected run length: expected end before 3000 cycles, seen timeout");
        report_and_stop();
    end
endmodule : trellis_encoder_ctrl_regs_tb
